// ===== lwn_link_model.sv
// link controller model: powers up after seeing wake edges
module lwn_link_model (
  // clock
  input  wire logic       core_clk,
  // wake pin and bench controls
  input  wire logic       wake_pin,
  input  wire logic       power_off,
  input  wire logic [7:0] wake_delay,
  // power status to the phy
  output logic            link_power_sense
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       last_r;
  logic [7:0] seen_r;
  initial begin
    last_r = 1'b0;
    seen_r = 8'h00;
    link_power_sense = 1'b0;
  end
  // wake_delay edges before power-up gives prompt or slow answers
  always @(posedge core_clk) begin
    last_r <= wake_pin;
    if (power_off) begin
      seen_r <= 8'h00;
      link_power_sense <= 1'b0;
    end else if (wake_pin != last_r && seen_r != 8'hFF) begin
      seen_r <= seen_r + 8'h01;
    end else if (seen_r >= wake_delay) begin
      link_power_sense <= 1'b1;
    end
  end
endmodule

// ===== lwn_pkg.sv
// constants shared by the wake notifier design
package lwn_pkg;
  // system clock rate
  localparam int unsigned CLK_MHZ          = 250;
  // wake square wave: period in cycles, toggle every half period
  localparam int unsigned WAKE_PERIOD_CYC  = 8;
  localparam int unsigned WAKE_HALF_CYC    = WAKE_PERIOD_CYC / 2;
  // link power sense low time before judged inactive
  localparam int unsigned LPS_LOW_NS_X10   = 26;
  localparam int unsigned LPS_LOW_CYC      = 128;
  localparam int unsigned LPS_CNT_W        = 8;
  // pin input synchroniser depth
  localparam int unsigned SYNC_STAGES      = 3;
  // reset values
  localparam logic        WAKE_RST_VAL     = 1'b0;
  localparam logic        CONTENDER_RST    = 1'b0;
endpackage

// ===== lwn_sync.sv
// three-stage pin synchroniser with second/third agreement filter
module lwn_sync (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // asynchronous input and filtered level
  input  wire logic async_in,
  output logic      level_out
);
  import lwn_pkg::*;

  logic s1_r;
  logic s2_r;
  logic s3_r;

  // stage one feeds only stage two
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // accept a change only once stages two and three agree
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      level_out <= 1'b0;
    end else if (s2_r == s3_r) begin
      level_out <= s3_r;
    end
  end
endmodule

// ===== lwn_wake_notifier.sv
// wake notification, contender strap and cable idle logic
// Overview of operation
// - strap sampled at reset sets contender default
// - active wake is eight-cycle square wave
// - inactive wake low, undriven during reset
// - link inactive if sense or ctrl low
// - link-on packet wakes inactive link
// - port event bit wakes inactive link
// - timeout/power bits wake when enabled
// - wake holds until link becomes active
// - bus reset drops packet-only wake
// - pending interrupt wakes once link inactive
// - cable idle high when no bias
// - sense inactive after 128 low cycles
//
// Implementation choices: the address map and the strobed register port.
module lwn_wake_notifier #(
  parameter int unsigned NUM_PORTS = 6
) (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  // contender / wake pin, split into three signals
  input  wire logic                 contender_wake_pin_i,
  output logic                      contender_wake_pin_o,
  output logic                      contender_wake_pin_oe,
  // strapped contender default
  output logic                      contender_default,
  // link controller status
  input  wire logic                 link_power_sense,
  input  wire logic                 link_active_ctrl_bit,
  // wake causes from the rest of the phy
  input  wire logic                 link_on_pkt_rx,
  input  wire logic                 bus_reset,
  input  wire logic                 port_event_irq_bit,
  input  wire logic                 config_timeout_irq_bit,
  input  wire logic                 cable_power_irq_bit,
  input  wire logic                 state_timeout_irq_bit,
  input  wire logic                 resuming_port_irq_enable,
  // cable bias detection per port
  input  wire logic [NUM_PORTS-1:0] port_bias_detect,
  // status outputs
  output logic                      cable_idle_output,
  output logic                      link_active,
  // software register port
  input  wire logic [3:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [31:0]               reg_rdata,
  // interrupt
  output logic                      irq
);
  import lwn_pkg::*;

  // register map
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_MASK   = 4'h4;
  localparam logic [3:0] ADDR_STATE  = 4'h8;
  localparam logic [3:0] ADDR_CTRL   = 4'hC;
  // event bit positions
  localparam int unsigned EV_WAKE_ON  = 0;
  localparam int unsigned EV_WAKE_OFF = 1;
  localparam int unsigned EV_LPS_LOST = 2;
  localparam int unsigned EV_CBL_IDLE = 3;
  localparam int unsigned EV_W        = 4;

  // write decode shared by every writable register
  function automatic logic wr_hit(logic wr, logic [3:0] a, logic [3:0] want);
    return wr && (a == want);
  endfunction

  // event-wide registers read back zero-extended
  function automatic logic [31:0] pad_ev(logic [EV_W-1:0] v);
    return {28'h0000000, v};
  endfunction

  // synchronised pin levels and sense filter
  logic                 lps_sync;
  logic                 strap_sync;
  logic [LPS_CNT_W-1:0] lps_low_cnt_r;
  logic                 lps_active_r;
  // wake state and wave generator
  logic                 wake_r;
  logic                 wake_pkt_r;
  logic [1:0]           half_cnt_r;
  logic                 wave_r;
  logic                 irq_cause;
  logic                 link_act;
  logic                 link_act_d_r;
  logic                 wake_d_r;
  logic                 idle_d_r;
  logic                 idle_now;
  // event and register state
  logic [5:0]           state_word;
  logic [EV_W-1:0]      ev;
  logic [EV_W-1:0]      status_r;
  logic [EV_W-1:0]      mask_r;
  logic                 force_wake_r;
  // bias sampling
  logic [NUM_PORTS-1:0] bias_s1_r;
  logic [NUM_PORTS-1:0] bias_s2_r;

  // link power sense comes from another chip: filtered
  // reset tied off so the filter keeps tracking the pin
  lwn_sync u_lps_sync (
    .core_clk  (core_clk),
    .sys_rst   (1'b0),
    .async_in  (link_power_sense),
    .level_out (lps_sync)
  );

  // strap level; synchroniser left running through reset to track pin
  lwn_sync u_strap_sync (
    .core_clk  (core_clk),
    .sys_rst   (1'b0),
    .async_in  (contender_wake_pin_i),
    .level_out (strap_sync)
  );

  // strap captured while reset is held, reads settled pin level
  // reset must last a few cycles so the filtered level settles
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      contender_default <= strap_sync;
    end
  end

  // low-time counter; a short low glitch keeps sense active
  // counter holds at the limit so a long low cannot wrap
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lps_low_cnt_r <= '0;
      lps_active_r  <= 1'b0;
    end else if (lps_sync) begin
      lps_low_cnt_r <= '0;
      lps_active_r  <= 1'b1;
    end else if (lps_low_cnt_r < LPS_CNT_W'(LPS_LOW_CYC)) begin
      lps_low_cnt_r <= lps_low_cnt_r + LPS_CNT_W'(1);
    end else begin
      lps_active_r  <= 1'b0;
    end
  end

  // link counts as active only with sense and control bit both up
  assign link_act = lps_active_r & link_active_ctrl_bit;

  // interrupt causes; software may also force a wake
  assign irq_cause = port_event_irq_bit
                   | ((config_timeout_irq_bit | cable_power_irq_bit
                      | state_timeout_irq_bit) & resuming_port_irq_enable)
                   | force_wake_r;

  // wake request state; level causes re-evaluated every cycle
  // a live interrupt cause outranks the packet, so a bus reset
  // only drops a wake when no interrupt cause or packet is live
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wake_r     <= WAKE_RST_VAL;
      wake_pkt_r <= 1'b0;
    end else if (link_act) begin
      wake_r     <= 1'b0;
      wake_pkt_r <= 1'b0;
    end else if (irq_cause) begin
      wake_r     <= 1'b1;
      wake_pkt_r <= wake_pkt_r | link_on_pkt_rx;
    end else if (link_on_pkt_rx) begin
      wake_r     <= 1'b1;
      wake_pkt_r <= 1'b1;
    end else if (bus_reset) begin
      wake_r     <= 1'b0;
      wake_pkt_r <= 1'b0;
    end
  end

  // square wave: toggle every half period for fifty percent duty
  // counter restarts while wake is off, so the first half is full
  always_ff @(posedge core_clk) begin
    if (sys_rst || !wake_r) begin
      half_cnt_r <= '0;
      wave_r     <= 1'b0;
    end else if (half_cnt_r == 2'(WAKE_HALF_CYC - 1)) begin
      half_cnt_r <= '0;
      wave_r     <= ~wave_r;
    end else begin
      half_cnt_r <= half_cnt_r + 2'(1);
    end
  end

  // pin drive: undriven in reset, low when idle, wave when active
  // idle level is a driven low, never left floating after reset
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      contender_wake_pin_oe <= 1'b0;
      contender_wake_pin_o  <= 1'b0;
    end else begin
      contender_wake_pin_oe <= 1'b1;
      contender_wake_pin_o  <= wake_r & wave_r;
    end
  end

  // bias detect is analog, so double-sample it
  // a port losing bias shows up two flops later
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      bias_s1_r <= '0;
      bias_s2_r <= '0;
    end else begin
      bias_s1_r <= port_bias_detect;
      bias_s2_r <= bias_s1_r;
    end
  end

  // not debounced: follows the double-sampled ports
  assign idle_now = ~|bias_s2_r;

  // registered status outputs
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cable_idle_output <= 1'b1;
      link_active       <= 1'b0;
    end else begin
      cable_idle_output <= idle_now;
      link_active       <= link_act;
    end
  end

  // edge history for event detection
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      link_act_d_r <= 1'b0;
      wake_d_r     <= 1'b0;
      idle_d_r     <= 1'b1;
    end else begin
      link_act_d_r <= lps_active_r;
      wake_d_r     <= wake_r;
      idle_d_r     <= idle_now;
    end
  end

  // one-cycle event pulses from level changes
  assign ev[EV_WAKE_ON]  = wake_r & ~wake_d_r;
  assign ev[EV_WAKE_OFF] = ~wake_r & wake_d_r;
  assign ev[EV_LPS_LOST] = ~lps_active_r & link_act_d_r;
  assign ev[EV_CBL_IDLE] = idle_now & ~idle_d_r;

  // state word: sense, link, wake, packet wake, cable idle, contender
  assign state_word[0] = lps_active_r;
  assign state_word[1] = link_act;
  assign state_word[2] = wake_r;
  assign state_word[3] = wake_pkt_r;
  assign state_word[4] = idle_now;
  assign state_word[5] = contender_default;

  // sticky status: a new event wins over a write-one clear
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      status_r <= '0;
    end else if (wr_hit(reg_wr, reg_addr, ADDR_STATUS)) begin
      status_r <= (status_r & ~reg_wdata[EV_W-1:0]) | ev;
    end else begin
      status_r <= status_r | ev;
    end
  end

  // mask and control registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mask_r       <= '0;
      force_wake_r <= 1'b0;
    end else if (wr_hit(reg_wr, reg_addr, ADDR_MASK)) begin
      mask_r       <= reg_wdata[EV_W-1:0];
    end else if (wr_hit(reg_wr, reg_addr, ADDR_CTRL)) begin
      force_wake_r <= reg_wdata[0];
    end
  end

  // read data valid the cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_STATUS: reg_rdata <= pad_ev(status_r);
        ADDR_MASK:   reg_rdata <= pad_ev(mask_r);
        ADDR_STATE:  reg_rdata <= {26'h0000000, state_word};
        ADDR_CTRL:   reg_rdata <= {31'h00000000, force_wake_r};
        default:     reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // level interrupt from any unmasked sticky bit
  // a write-one clear drops irq two cycles after the strobe
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_r & mask_r);
    end
  end
endmodule

// ===== lwn_wake_notifier_assertions.sv
// port checker for the wake notifier
module lwn_wake_notifier_assertions #(
  parameter int unsigned NUM_PORTS = 6
) (
  // clock and reset
  input wire logic                 core_clk,
  input wire logic                 sys_rst,
  // pin and link
  input wire logic                 contender_wake_pin_o,
  input wire logic                 contender_wake_pin_oe,
  input wire logic                 link_power_sense,
  input wire logic                 link_active_ctrl_bit,
  input wire logic                 link_active,
  // wake causes
  input wire logic                 link_on_pkt_rx,
  input wire logic                 bus_reset,
  input wire logic                 port_event_irq_bit,
  input wire logic                 config_timeout_irq_bit,
  input wire logic                 cable_power_irq_bit,
  input wire logic                 state_timeout_irq_bit,
  input wire logic                 resuming_port_irq_enable,
  // cables
  input wire logic [NUM_PORTS-1:0] port_bias_detect,
  input wire logic                 cable_idle_output
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic       o;
  logic       cause;
  logic       irq_seen_r;
  logic [7:0] low_cnt_r;
  assign o     = contender_wake_pin_o;
  assign cause = port_event_irq_bit | (resuming_port_irq_enable & (config_timeout_irq_bit
                 | cable_power_irq_bit | state_timeout_irq_bit));
  // saturating count of low sense samples
  always_ff @(posedge core_clk) begin
    if (sys_rst || link_power_sense) low_cnt_r <= 8'h00;
    else if (low_cnt_r != 8'hFF) low_cnt_r <= low_cnt_r + 8'h01;
  end
  // wake not packet-only once an irq cause met a down link
  always_ff @(posedge core_clk) begin
    if (sys_rst || link_active) irq_seen_r <= 1'b0;
    else if (cause) irq_seen_r <= 1'b1;
  end
  sequence quiet_s;
    (!link_active && !bus_reset)[*7];
  endsequence
  sequence no_cause_s;
    (!cause && !link_on_pkt_rx)[*6];
  endsequence
  hiz_reset_a: assert property (disable iff (1'b0) sys_rst |=> !contender_wake_pin_oe)
    else $error("pin driven in reset");
  low_half_a: assert property ($fell(o) |=> !o[*3])
    else $error("low half too short");
  high_end_a: assert property ($rose(o) |-> ##4 !o)
    else $error("high half wrong");
  wake_stop_a: assert property (link_active[*4] |-> !o)
    else $error("wake with link up");
  wake_start_a: assert property ((link_on_pkt_rx || cause) ##0 quiet_s |-> ##[0:4] o)
    else $error("no wake");
  packet_drop_a: assert property (bus_reset && !irq_seen_r ##0 no_cause_s |-> !o)
    else $error("wake kept after bus reset");
  link_ctrl_a: assert property (!link_active_ctrl_bit |=> !link_active)
    else $error("link active without ctrl");
  sense_lost_a: assert property (low_cnt_r > 8'h8C |-> !link_active)
    else $error("link active with sense low");
  idle_on_a: assert property ((port_bias_detect == '0)[*4] |-> cable_idle_output)
    else $error("cable idle missing");
endmodule

bind lwn_wake_notifier lwn_wake_notifier_assertions #(.NUM_PORTS(NUM_PORTS)) i_chk (.*);

// ===== tb_top.sv
// self-checking bench for the wake notifier
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lwn_pkg::*;
  localparam logic [4:0] CAUSES [7] = '{5'h01, 5'h12, 5'h14, 5'h18, 5'h02, 5'h04, 5'h08};
  logic        core_clk, sys_rst, strap, ctrl, pkt, brst, wr, rd, pwr_off, w;
  logic        pin_o, pin_oe, cdef, idle, lact, irq, sense;
  logic [4:0]  irqs;
  logic [5:0]  bias;
  logic [3:0]  addr;
  logic [7:0]  dly;
  logic [31:0] wdata, rdata, d;
  int          n_fail = 0, n_compared = 0, i, hi;
  wire         pin = pin_oe ? pin_o : strap;
  lwn_wake_notifier i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .contender_wake_pin_i(pin),
    .contender_wake_pin_o(pin_o), .contender_wake_pin_oe(pin_oe), .contender_default(cdef),
    .link_power_sense(sense), .link_active_ctrl_bit(ctrl), .link_on_pkt_rx(pkt),
    .bus_reset(brst), .port_event_irq_bit(irqs[0]), .config_timeout_irq_bit(irqs[1]),
    .cable_power_irq_bit(irqs[2]), .state_timeout_irq_bit(irqs[3]),
    .resuming_port_irq_enable(irqs[4]), .port_bias_detect(bias), .cable_idle_output(idle),
    .link_active(lact), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata), .irq(irq));
  lwn_link_model i_llc (.core_clk(core_clk), .wake_pin(pin), .power_off(pwr_off),
    .wake_delay(dly), .link_power_sense(sense));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  function automatic logic wake_exp(logic [4:0] v);
    return v[0] | (v[4] & |v[3:1]);
  endfunction
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic clk(int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr_reg(logic [3:0] a, logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    clk(1);
    wr <= 1'b0;
  endtask
  // data is taken at the edge that closes its one valid cycle
  task automatic rd_reg(logic [3:0] a, output logic [31:0] v);
    addr <= a;
    rd <= 1'b1;
    clk(1);
    rd <= 1'b0;
    clk(1);
    v = rdata;
  endtask
  // count pin transitions over n cycles; a running wave gives n/4
  task automatic watch(int n, output int e);
    logic p;
    e = 0;
    p = pin;
    repeat (n) begin
      clk(1);
      if (pin !== p) e++;
      p = pin;
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    clk(20000);
    n_fail++;
    give_verdict();
  end
  initial begin
    i = $urandom(2704);
    {sys_rst, strap, ctrl, pkt, brst, wr, rd, pwr_off} <= 8'hE1;
    {irqs, bias, addr, wdata, dly} <= '0;
    // strap high in the first reset, low in the second
    clk(10);
    chk(pin_oe, 1'b0);
    chk(cdef, 1'b1);
    sys_rst <= 1'b0;
    clk(2);
    chk(pin_oe, 1'b1);
    chk(pin_o, 1'b0);
    sys_rst <= 1'b1;
    strap <= 1'b0;
    clk(10);
    chk(cdef, 1'b0);
    sys_rst <= 1'b0;
    clk(1);
    // packet wake, masked then unmasked interrupt, bus reset drop
    wr_reg(4'h0, 32'h0000000F);
    pkt <= 1'b1;
    clk(1);
    pkt <= 1'b0;
    clk(8);
    chk(irq, 1'b0);
    wr_reg(4'h4, 32'h0000000F);
    watch(16, hi);
    chk(hi, 4);
    chk(irq, 1'b1);
    rd_reg(4'h0, d);
    chk(d, 32'h00000001);
    rd_reg(4'h8, d);
    chk(d, 32'h0000001C);
    rd_reg(4'h2, d);
    chk(d, 32'h00000000);
    wr_reg(4'h0, 32'h0000000F);
    clk(2);
    chk(irq, 1'b0);
    brst <= 1'b1;
    clk(1);
    brst <= 1'b0;
    clk(3);
    watch(16, hi);
    chk(hi, 0);
    // software force-wake acts as a cause; bus reset drops it once cleared
    wr_reg(4'hC, 32'h00000001);
    clk(8);
    watch(16, hi);
    chk(hi, 4);
    rd_reg(4'hC, d);
    chk(d, 32'h00000001);
    wr_reg(4'hC, 32'h00000000);
    brst <= 1'b1;
    clk(1);
    brst <= 1'b0;
    clk(3);
    watch(16, hi);
    chk(hi, 0);
    // port event, each other cause with and without enable, then random mixes
    for (i = 0; i < 12; i++) begin
      irqs <= (i < 7) ? CAUSES[i] : 5'($urandom);
      bias <= i[0] ? 6'h00 : 6'($urandom_range(63, 1));
      dly <= 8'($urandom_range(6, 1));
      clk(1);
      brst <= 1'b1;
      clk(1);
      brst <= 1'b0;
      clk(8);
      w = wake_exp(irqs);
      watch(16, hi);
      chk(hi, w ? 4 : 0);
      chk(idle, bias === 6'h00);
      irqs <= 5'h00;
      pwr_off <= 1'b0;
      clk(60);
      chk(lact, w);
      watch(16, hi);
      chk(hi, 0);
      pwr_off <= 1'b1;
      clk(150);
    end
    // cause pending while the link is up wakes once it drops
    dly <= 8'h02;
    pwr_off <= 1'b0;
    irqs <= 5'h01;
    clk(60);
    watch(16, hi);
    chk(hi, 0);
    ctrl <= 1'b0;
    clk(8);
    watch(16, hi);
    chk(hi, 4);
    ctrl <= 1'b1;
    pwr_off <= 1'b1;
    clk(LPS_LOW_CYC - 20);
    chk(lact, 1'b1);
    clk(42);
    watch(16, hi);
    chk(hi, 4);
    give_verdict();
  end
endmodule
